// File: design/sleep_seq.sv
// system sleep state sequencer with active-low plane controls
//
// Our own choices: the placing of the registers and the plain strobed port.
`include "sleep_seq_consts.svh"
`default_nettype none
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
module sleep_seq #(
    parameter int unsigned WAKE_W = 8
) (
    input  wire logic              clk_sys,
    input  wire logic              rstn,
    input  wire logic [3:0]        reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [31:0]       reg_rdata,
    input  wire logic [WAKE_W-1:0] wake_event,
    input  wire logic              pwr_button_override,
    input  wire logic              power_fail,
    input  wire logic              battery_low_n,
    input  wire logic              ac_power_present,
    input  wire logic              deep_sleep_ok,
    input  wire logic              mgmt_off,
    input  wire logic              mgmt_power_gated_state,
    output logic                   s3_plane_off_n,
    output logic                   s4_plane_off_n,
    output logic                   s5_plane_off_n,
    output logic                   mgmt_plane_off_n,
    output logic                   lan_plane_off_n,
    output logic                   primary_well_off_n
);
    localparam int unsigned SETTLE = `SSQ_SETTLE_CYC;

    // ------------------------------------------------------------------------
    // pin synchronisers; reset reads as power failed, so no early power-return choice
    // ------------------------------------------------------------------------
    localparam int unsigned NS = WAKE_W + 7;
    logic [NS-1:0] sy1_q;
    logic [NS-1:0] sy2_q;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            sy1_q <= {{WAKE_W{1'b0}}, `SSQ_SYNC_RST};
            sy2_q <= {{WAKE_W{1'b0}}, `SSQ_SYNC_RST};
        end else begin
            sy1_q <= {wake_event, pwr_button_override, power_fail, ~battery_low_n,
                      ac_power_present, deep_sleep_ok, mgmt_off, mgmt_power_gated_state};
            sy2_q <= sy1_q;
        end
    end
    logic [WAKE_W-1:0] wake_s;
    logic ovr_s, fail_s, battery_low_n_s, ac_s, deep_ok_s, moff_s, mpg_s;
    assign {wake_s, ovr_s, fail_s, battery_low_n_s, ac_s, deep_ok_s, moff_s, mpg_s} = sy2_q;

    // ------------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------------
    logic [7:0]        ctrl_q, ctrl_d;
    logic [WAKE_W-1:0] wake_en_q, wake_en_d;
    logic [WAKE_W-1:0] wake_pend_q, wake_pend_d;
    logic [31:0]       rdata_q, rdata_d;
    sleep_seq_pkg::pstate_type st_q, st_d;
    sleep_seq_pkg::pstate_type prior_q, prior_d;   // state held before power loss
    sleep_seq_pkg::pstate_type tgt_q, tgt_d;       // final state of a stepped move
    logic deep_from_s4_q, deep_from_s4_d;
    logic ovr_entry_q, ovr_entry_d;
    logic s4_seen_q, s4_seen_d;                    // s4 visited before g3

    logic settle_start;
    logic settle_done;

    sleep_seq_settle #(.CYCLES(SETTLE)) u_settle (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .start   (settle_start),
        .done    (settle_done)
    );

    function automatic logic is_sleep(input sleep_seq_pkg::pstate_type s);
        return (s == sleep_seq_pkg::ST_SUSPEND_RAM) || (s == sleep_seq_pkg::ST_SUSPEND_DISK) ||
               (s == sleep_seq_pkg::ST_SOFT_OFF) || (s == sleep_seq_pkg::ST_DEEP_SLEEP);
    endfunction : is_sleep

    wire wake_any = |(wake_pend_q & wake_en_q);
    wire slp_req  = ctrl_q[`SSQ_CTRL_SLP];

    // ------------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------------
    always_comb begin
        st_d           = st_q;
        prior_d        = prior_q;
        tgt_d          = tgt_q;
        deep_from_s4_d = deep_from_s4_q;
        ovr_entry_d    = ovr_entry_q;
        s4_seen_d      = s4_seen_q;
        settle_start   = 1'b0;
        if (fail_s && st_q != sleep_seq_pkg::ST_MECH_OFF) begin
            prior_d = s4_seen_q ? sleep_seq_pkg::ST_SUSPEND_DISK : st_q; // power loss wins
            ovr_entry_d = 1'b0;
            st_d    = sleep_seq_pkg::ST_MECH_OFF;
        end else if (!fail_s) begin
            case (st_q)
                sleep_seq_pkg::ST_FULL_ON, sleep_seq_pkg::ST_CPU_IDLE,
                sleep_seq_pkg::ST_SUSPEND_RAM: begin
                    s4_seen_d = 1'b0;
                    ovr_entry_d = 1'b0;
                    if (ovr_s) begin
                        st_d = sleep_seq_pkg::ST_SOFT_OFF;
                        ovr_entry_d = 1'b1;
                    end else if (st_q == sleep_seq_pkg::ST_SUSPEND_RAM) begin
                        if (wake_any && !battery_low_n_s) begin
                            st_d = sleep_seq_pkg::ST_FULL_ON;
                        end
                    end else if (st_q == sleep_seq_pkg::ST_CPU_IDLE) begin
                        if (wake_any) begin
                            st_d = sleep_seq_pkg::ST_FULL_ON;
                        end
                    end else if (slp_req) begin
                        case (ctrl_q[`SSQ_CTRL_TGT_HI:`SSQ_CTRL_TGT_LO])
                            `SSQ_TGT_IDLE: st_d = sleep_seq_pkg::ST_CPU_IDLE;
                            `SSQ_TGT_S3:   st_d = sleep_seq_pkg::ST_SUSPEND_RAM;
                            `SSQ_TGT_S4:   st_d = sleep_seq_pkg::ST_SUSPEND_DISK;
                            default: begin
                                // soft-off steps through disk planes first
                                st_d  = sleep_seq_pkg::ST_STEP_OFF;
                                tgt_d = sleep_seq_pkg::ST_SOFT_OFF;
                                settle_start = 1'b1;
                            end
                        endcase
                    end
                end
                sleep_seq_pkg::ST_STEP_OFF: begin
                    if (settle_done) begin
                        st_d = tgt_q;
                    end
                end
                sleep_seq_pkg::ST_SUSPEND_DISK: begin
                    s4_seen_d = 1'b1;
                    if (ovr_s) begin
                        st_d = sleep_seq_pkg::ST_SOFT_OFF;
                        ovr_entry_d = 1'b1;
                    end else if (wake_any && !battery_low_n_s) begin
                        st_d = sleep_seq_pkg::ST_FULL_ON;
                    end else if (ctrl_q[`SSQ_CTRL_DEEP_EN] && deep_ok_s) begin
                        st_d = sleep_seq_pkg::ST_DEEP_SLEEP;
                        deep_from_s4_d = 1'b1;
                    end
                end
                sleep_seq_pkg::ST_SOFT_OFF: begin
                    s4_seen_d = 1'b0;
                    if (wake_any && !battery_low_n_s) begin
                        st_d = sleep_seq_pkg::ST_FULL_ON;
                    end else if (ctrl_q[`SSQ_CTRL_DEEP_EN] && deep_ok_s) begin
                        st_d = sleep_seq_pkg::ST_DEEP_SLEEP;
                        deep_from_s4_d = 1'b0;
                    end
                end
                sleep_seq_pkg::ST_DEEP_SLEEP: begin
                    if (ovr_s && !ovr_entry_q) begin // a served override rests here
                        st_d = sleep_seq_pkg::ST_SOFT_OFF;
                        ovr_entry_d = 1'b1;
                    end else if (wake_any && !battery_low_n_s) begin
                        st_d = sleep_seq_pkg::ST_FULL_ON;
                    end else if (ac_s) begin
                        st_d = deep_from_s4_q ? sleep_seq_pkg::ST_SUSPEND_DISK
                                              : sleep_seq_pkg::ST_SOFT_OFF;
                    end
                end
                default: begin
                    // mechanical off: power has returned once fail drops
                    if (prior_q == sleep_seq_pkg::ST_SUSPEND_DISK) begin
                        st_d = ctrl_q[`SSQ_CTRL_AFTER] ? sleep_seq_pkg::ST_SUSPEND_DISK
                                                       : sleep_seq_pkg::ST_FULL_ON;
                    end else begin
                        st_d = ctrl_q[`SSQ_CTRL_AFTER] ? sleep_seq_pkg::ST_SOFT_OFF
                                                       : sleep_seq_pkg::ST_FULL_ON;
                    end
                    // reboot into full-on from s4/s5 still respects battery low
                    if (st_d == sleep_seq_pkg::ST_FULL_ON && battery_low_n_s) begin
                        st_d = sleep_seq_pkg::ST_SOFT_OFF;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // wake latch: pending bits survive power failure, cleared on full-on
    // ------------------------------------------------------------------------
    always_comb begin
        wake_pend_d = wake_pend_q;
        if (st_q == sleep_seq_pkg::ST_FULL_ON) begin
            wake_pend_d = '0;
        end
        wake_pend_d = wake_pend_d | wake_s;
    end

    // ------------------------------------------------------------------------
    // register port; the sleep entry bit self-clears once acted on
    // ------------------------------------------------------------------------
    always_comb begin
        ctrl_d    = ctrl_q;
        wake_en_d = wake_en_q;
        rdata_d   = 32'h0000_0000;
        if (st_q == sleep_seq_pkg::ST_FULL_ON && st_d != st_q) begin
            ctrl_d[`SSQ_CTRL_SLP] = 1'b0;
        end
        if (reg_wr) begin
            if (reg_addr == `SSQ_ADDR_CTRL) begin
                ctrl_d = reg_wdata[7:0];
            end else if (reg_addr == `SSQ_ADDR_WAKE_EN) begin
                wake_en_d = reg_wdata[WAKE_W-1:0];
            end
        end
        if (reg_rd) begin
            if (reg_addr == `SSQ_ADDR_CTRL) begin
                rdata_d = {24'h00_0000, ctrl_q};
            end else if (reg_addr == `SSQ_ADDR_WAKE_EN) begin
                rdata_d[WAKE_W-1:0] = wake_en_q;
            end else if (reg_addr == `SSQ_ADDR_STATE) begin
                rdata_d = {20'h0_0000, prior_q, 4'(st_q), wake_pend_q[3:0]};
            end else if (reg_addr == `SSQ_ADDR_PLANES) begin
                rdata_d = {26'h000_0000, primary_well_off_n, lan_plane_off_n,
                           mgmt_plane_off_n, s5_plane_off_n, s4_plane_off_n, s3_plane_off_n};
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            st_q           <= sleep_seq_pkg::ST_MECH_OFF;
            prior_q        <= sleep_seq_pkg::ST_SOFT_OFF;
            tgt_q          <= sleep_seq_pkg::ST_SOFT_OFF;
            deep_from_s4_q <= 1'b0;
            ovr_entry_q    <= 1'b0;
            s4_seen_q      <= 1'b0;
            wake_pend_q    <= '0;
            ctrl_q         <= `SSQ_CTRL_RST;
            wake_en_q      <= WAKE_W'(`SSQ_WAKE_EN_RST);
            rdata_q        <= 32'h0000_0000;
        end else begin
            st_q           <= st_d;
            prior_q        <= prior_d;
            tgt_q          <= tgt_d;
            deep_from_s4_q <= deep_from_s4_d;
            ovr_entry_q    <= ovr_entry_d;
            s4_seen_q      <= s4_seen_d;
            wake_pend_q    <= wake_pend_d;
            ctrl_q         <= ctrl_d;
            wake_en_q      <= wake_en_d;
            rdata_q        <= rdata_d;
        end
    end
    assign reg_rdata = rdata_q;

    // ------------------------------------------------------------------------
    // plane outputs, registered; our own supply rides only on the primary well
    // ------------------------------------------------------------------------
    logic s3_q, s4_q, s5_q, ma_q, lan_q, sus_q;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            {s3_q, s4_q, s5_q, ma_q, lan_q, sus_q} <= `SSQ_PLANES_RST;
        end else begin
            s3_q  <= is_sleep(st_d) || st_d == sleep_seq_pkg::ST_STEP_OFF ||
                     st_d == sleep_seq_pkg::ST_MECH_OFF;
            s4_q  <= (is_sleep(st_d) && st_d != sleep_seq_pkg::ST_SUSPEND_RAM) ||
                     st_d == sleep_seq_pkg::ST_STEP_OFF ||
                     st_d == sleep_seq_pkg::ST_MECH_OFF;
            s5_q  <= st_d == sleep_seq_pkg::ST_SOFT_OFF || st_d == sleep_seq_pkg::ST_MECH_OFF ||
                     (st_d == sleep_seq_pkg::ST_DEEP_SLEEP && !deep_from_s4_d);
            ma_q  <= moff_s || mpg_s || st_d == sleep_seq_pkg::ST_MECH_OFF;
            lan_q <= ((is_sleep(st_d) && (moff_s || mpg_s) &&
                      !ctrl_q[`SSQ_CTRL_HOST_WOL] && !ctrl_q[`SSQ_CTRL_MGMT_WOL]) ||
                      st_d == sleep_seq_pkg::ST_MECH_OFF);
            sus_q <= (st_d == sleep_seq_pkg::ST_DEEP_SLEEP && ctrl_q[`SSQ_CTRL_SUS_OK]) ||
                     st_d == sleep_seq_pkg::ST_MECH_OFF;
        end
    end
    assign s3_plane_off_n     = ~s3_q;
    assign s4_plane_off_n     = ~s4_q;
    assign s5_plane_off_n     = ~s5_q;
    assign mgmt_plane_off_n   = ~ma_q;
    assign lan_plane_off_n    = ~lan_q;
    assign primary_well_off_n = ~sus_q;

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    a_fail_to_mech: assert property (fail_s |=> st_q == sleep_seq_pkg::ST_MECH_OFF)
        else $error("power fail did not reach mechanical off");
    a_battery_low_n_holds: assert property (battery_low_n_s && st_q == sleep_seq_pkg::ST_SOFT_OFF && !fail_s
        |=> st_q != sleep_seq_pkg::ST_FULL_ON)
        else $error("full-on entered from soft-off while battery low");
    a_ovr_soft_off: assert property (ovr_s && !fail_s && st_q == sleep_seq_pkg::ST_FULL_ON
        |=> st_q == sleep_seq_pkg::ST_SOFT_OFF)
        else $error("override did not force soft-off");
    a_s3_follows: assert property (st_q == sleep_seq_pkg::ST_SUSPEND_RAM |-> !s3_plane_off_n)
        else $error("s3 output not asserted in suspend-to-ram");
    a_s4_follows: assert property ($rose(st_q == sleep_seq_pkg::ST_SUSPEND_DISK)
        |-> !s4_plane_off_n && s5_plane_off_n)
        else $error("s4 output wrong on disk entry");
    a_s5_follows: assert property (st_q == sleep_seq_pkg::ST_SOFT_OFF |-> !s5_plane_off_n)
        else $error("s5 output not asserted in soft-off");
    a_deep_return: assert property (st_q == sleep_seq_pkg::ST_DEEP_SLEEP && ac_s && !ovr_s &&
        !fail_s && !wake_any && deep_from_s4_q |=> st_q == sleep_seq_pkg::ST_SUSPEND_DISK)
        else $error("deep sleep did not return to disk");
    a_step_bound: assert property (st_q == sleep_seq_pkg::ST_STEP_OFF && !fail_s
        |-> ##[1:40] st_q != sleep_seq_pkg::ST_STEP_OFF)
        else $error("soft-off step stuck");
    a_full_on_on: assert property (st_q == sleep_seq_pkg::ST_FULL_ON |=> !$past(fail_s)
        |-> s3_plane_off_n || st_q != sleep_seq_pkg::ST_FULL_ON)
        else $error("s3 asserted while full-on");

    c_sleep_wake:  cover property (st_q == sleep_seq_pkg::ST_SUSPEND_RAM ##[1:20]
                                   st_q == sleep_seq_pkg::ST_FULL_ON);
    c_deep_entry:  cover property (st_q == sleep_seq_pkg::ST_DEEP_SLEEP);
    c_power_back:  cover property (st_q == sleep_seq_pkg::ST_MECH_OFF ##1
                                   st_q == sleep_seq_pkg::ST_SUSPEND_DISK);
endmodule : sleep_seq
`default_nettype wire

// File: design/sleep_seq_consts.svh
// constants for the system sleep state sequencer
`ifndef SLEEP_SEQ_CONSTS_SVH
`define SLEEP_SEQ_CONSTS_SVH

// ----------------------------------------------------------------------------
// register map (word offsets on the plain register port)
// ----------------------------------------------------------------------------
`define SSQ_ADDR_CTRL     4'h0
`define SSQ_ADDR_WAKE_EN  4'h1
`define SSQ_ADDR_STATE    4'h2
`define SSQ_ADDR_PLANES   4'h3
// ctrl fields
`define SSQ_CTRL_SLP      0
`define SSQ_CTRL_TGT_LO   1
`define SSQ_CTRL_TGT_HI   2
`define SSQ_CTRL_AFTER    3
`define SSQ_CTRL_DEEP_EN  4
`define SSQ_CTRL_HOST_WOL 5
`define SSQ_CTRL_MGMT_WOL 6
`define SSQ_CTRL_SUS_OK   7
`define SSQ_CTRL_RST      8'h00
`define SSQ_WAKE_EN_RST   8'hff
// in reset every plane is asserted and the pins read as power failed
`define SSQ_PLANES_RST    6'h3f
`define SSQ_SYNC_RST      7'h20
// sleep targets written with the sleep entry bit
`define SSQ_TGT_IDLE      2'h0
`define SSQ_TGT_S3        2'h1
`define SSQ_TGT_S4        2'h2
`define SSQ_TGT_S5        2'h3
// ----------------------------------------------------------------------------
// timing: plane settle time between sequence steps
// ----------------------------------------------------------------------------
`define SSQ_CLK_MHZ       250
`define SSQ_SETTLE_NS     100
`define SSQ_SETTLE_CYC    ((`SSQ_SETTLE_NS * `SSQ_CLK_MHZ + 999) / 1000)

`endif

// File: design/sleep_seq_pkg.sv
// types for the system sleep state sequencer
`default_nettype none
package sleep_seq_pkg;
    typedef enum logic [3:0] {
        ST_FULL_ON,
        ST_CPU_IDLE,
        ST_SUSPEND_RAM,
        ST_SUSPEND_DISK,
        ST_SOFT_OFF,
        ST_DEEP_SLEEP,
        ST_MECH_OFF,
        ST_STEP_OFF
    } pstate_type;
endpackage : sleep_seq_pkg
`default_nettype wire

// File: design/sleep_seq_settle.sv
// settle timer between sequencer steps
`default_nettype none
module sleep_seq_settle #(
    parameter int unsigned CYCLES = 25
) (
    input  wire logic clk_sys,
    input  wire logic rstn,
    input  wire logic start,
    output logic      done
);
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;

    // ------------------------------------------------------------------------
    // down counter, done for the one cycle the count stands at one
    // ------------------------------------------------------------------------
    always_comb begin
        cnt_d = cnt_q;
        if (start) begin
            cnt_d = 8'(CYCLES);
        end else if (cnt_q != 8'h00) begin
            cnt_d = cnt_q - 8'h01;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= 8'h00;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign done = (cnt_q == 8'h01);
endmodule : sleep_seq_settle
`default_nettype wire

// File: dv/rail_ctrl_model.sv
// platform rail controller model facing the sleep outputs
`default_nettype none
module rail_ctrl_model #(
    parameter int unsigned DRAIN = 12
) (
    input  wire logic clk_sys,
    input  wire logic rstn,
    input  wire logic s4_plane_off_n,
    input  wire logic primary_well_off_n,
    input  wire logic ac_power_present,
    output logic      deep_sleep_ok,
    output logic      ctrl_supply_on
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] drain_q;
    // memory rails need time to bleed down before deep sleep is safe
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn)
            drain_q <= 8'h00;
        else if (s4_plane_off_n)
            drain_q <= 8'h00;
        else if (drain_q != DRAIN[7:0])
            drain_q <= drain_q + 8'h01;
    end
    // deep sleep only when on battery and rails fully drained
    assign deep_sleep_ok  = (drain_q == DRAIN[7:0]) && !ac_power_present;
    // controller supply hangs on the primary well, never on the s3 plane
    assign ctrl_supply_on = primary_well_off_n;
endmodule : rail_ctrl_model
`default_nettype wire

// File: dv/test_sleep_seq.sv
// self-checking bench for the sleep state sequencer
`include "sleep_seq_consts.svh"
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin failures++; \
    $display("Error t=%0t got %h exp %h", $time, g, e); end end
module test_sleep_seq;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys, rstn, reg_wr, reg_rd, pwr_button_override, power_fail;
    logic [3:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, state_word;
    logic [7:0]  wake_event;
    logic        battery_low_n, ac_power_present, deep_sleep_ok, mgmt_off;
    logic        mgmt_power_gated_state, ctrl_supply_on;
    logic        s3_plane_off_n, s4_plane_off_n, s5_plane_off_n;
    logic        mgmt_plane_off_n, lan_plane_off_n, primary_well_off_n;
    int          failures = 0;
    int          tests_run = 0;
    sleep_seq #(.WAKE_W(8)) sleep_seq_inst (.clk_sys, .rstn, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .wake_event, .pwr_button_override, .power_fail,
        .battery_low_n, .ac_power_present, .deep_sleep_ok, .mgmt_off,
        .mgmt_power_gated_state, .s3_plane_off_n, .s4_plane_off_n, .s5_plane_off_n,
        .mgmt_plane_off_n, .lan_plane_off_n, .primary_well_off_n);
    rail_ctrl_model rail_ctrl_model_inst (.clk_sys, .rstn, .s4_plane_off_n,
        .primary_well_off_n, .ac_power_present, .deep_sleep_ok, .ctrl_supply_on);
    // ------------------------------------------------------------------------
    // expectations and bus tasks
    // ------------------------------------------------------------------------
    // plane word {s3,s4,s5,mgmt,lan,sus} with management running
    function automatic logic [5:0] planes(sleep_seq_pkg::pstate_type s, logic sus);
        case (s)
            sleep_seq_pkg::ST_FULL_ON, sleep_seq_pkg::ST_CPU_IDLE: return 6'h3f;
            sleep_seq_pkg::ST_SUSPEND_RAM:  return 6'h1f;
            sleep_seq_pkg::ST_SUSPEND_DISK: return 6'h0f;
            sleep_seq_pkg::ST_SOFT_OFF:     return 6'h07;
            sleep_seq_pkg::ST_DEEP_SLEEP:   return {5'h03, !sus};
            default:                        return 6'h00;
        endcase
    endfunction : planes
    task automatic wr(logic [3:0] a, logic [31:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask : wr
    // read data stands only in the cycle after the strobe edge
    task automatic rd(logic [3:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
    // poll the state word under a bound, then compare state, and planes only while management runs
    task automatic wait_st(sleep_seq_pkg::pstate_type e, logic sus);
        logic [31:0] d;
        for (int i = 0; i < 200; i++) begin
            rd(`SSQ_ADDR_STATE, d);
            if (d[7:4] === e) break;
        end
        repeat (2) @(posedge clk_sys);
        `CHK(d[7:4], e)
        if (!(mgmt_off | mgmt_power_gated_state))
            `CHK({s3_plane_off_n, s4_plane_off_n, s5_plane_off_n, mgmt_plane_off_n,
                  lan_plane_off_n, primary_well_off_n}, planes(e, sus))
    endtask : wait_st
    // one random wake source, held long enough to cross the synchroniser
    task automatic wake();
        @(posedge clk_sys) wake_event <= 8'h01 << $urandom_range(7, 0);
        repeat (4) @(posedge clk_sys);
        wake_event <= 8'h00;
    endtask : wake
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_of_test
    // 4 ns clock
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    // the whole sequence should need well under 25k cycles
    initial begin
        #100us;
        failures++;
        end_of_test();
    end
    // main sequence
    initial begin
        {reg_wr, reg_rd, pwr_button_override, power_fail, mgmt_off} = '0;
        {mgmt_power_gated_state, reg_addr, reg_wdata, wake_event} = '0;
        {battery_low_n, ac_power_present, rstn} = 3'b110;
        void'($urandom(32'h08f3));
        repeat (5) @(posedge clk_sys);
        rstn <= 1'b1;
        wait_st(sleep_seq_pkg::ST_FULL_ON, 1'b0);
        wr(`SSQ_ADDR_CTRL, 32'h0000_0001);
        wait_st(sleep_seq_pkg::ST_CPU_IDLE, 1'b0);
        wake();
        wait_st(sleep_seq_pkg::ST_FULL_ON, 1'b0);
        @(posedge clk_sys) {mgmt_off, mgmt_power_gated_state} <= 2'($urandom_range(3, 1));
        repeat (6) @(posedge clk_sys);
        `CHK({mgmt_plane_off_n, lan_plane_off_n}, 2'b01)
        wr(`SSQ_ADDR_CTRL, 32'h0000_0003);
        wait_st(sleep_seq_pkg::ST_SUSPEND_RAM, 1'b0);
        `CHK({s3_plane_off_n, lan_plane_off_n, ctrl_supply_on}, 3'b001)
        @(posedge clk_sys) {mgmt_off, mgmt_power_gated_state} <= 2'b00;
        wr(`SSQ_ADDR_WAKE_EN, 32'h0000_0000);
        wake();
        repeat (10) @(posedge clk_sys);
        wait_st(sleep_seq_pkg::ST_SUSPEND_RAM, 1'b0);
        wr(`SSQ_ADDR_WAKE_EN, 32'h0000_00ff);
        wait_st(sleep_seq_pkg::ST_FULL_ON, 1'b0);
        wr(`SSQ_ADDR_CTRL, 32'h0000_0007);
        wait_st(sleep_seq_pkg::ST_SOFT_OFF, 1'b0);
        wake();
        wait_st(sleep_seq_pkg::ST_FULL_ON, 1'b0);
        wr(`SSQ_ADDR_CTRL, 32'h0000_0003);
        wait_st(sleep_seq_pkg::ST_SUSPEND_RAM, 1'b0);
        @(posedge clk_sys) pwr_button_override <= 1'b1;
        wait_st(sleep_seq_pkg::ST_SOFT_OFF, 1'b0);
        @(posedge clk_sys) pwr_button_override <= 1'b0;
        wake();
        wait_st(sleep_seq_pkg::ST_FULL_ON, 1'b0);
        wr(`SSQ_ADDR_CTRL, 32'h0000_000d);
        wait_st(sleep_seq_pkg::ST_SUSPEND_DISK, 1'b0);
        @(posedge clk_sys) power_fail <= 1'b1;
        wait_st(sleep_seq_pkg::ST_MECH_OFF, 1'b0);
        @(posedge clk_sys) power_fail <= 1'b0;
        wait_st(sleep_seq_pkg::ST_SUSPEND_DISK, 1'b0);
        @(posedge clk_sys) battery_low_n <= 1'b0;
        wake();
        repeat (40) @(posedge clk_sys);
        wait_st(sleep_seq_pkg::ST_SUSPEND_DISK, 1'b0);
        @(posedge clk_sys) battery_low_n <= 1'b1;
        wait_st(sleep_seq_pkg::ST_FULL_ON, 1'b0);
        wr(`SSQ_ADDR_CTRL, 32'h0000_0008);
        @(posedge clk_sys) power_fail <= 1'b1;
        wait_st(sleep_seq_pkg::ST_MECH_OFF, 1'b0);
        @(posedge clk_sys) power_fail <= 1'b0;
        wait_st(sleep_seq_pkg::ST_SOFT_OFF, 1'b0);
        @(posedge clk_sys) ac_power_present <= 1'b0;
        wr(`SSQ_ADDR_CTRL, 32'h0000_0098);
        wait_st(sleep_seq_pkg::ST_DEEP_SLEEP, 1'b1);
        @(posedge clk_sys) ac_power_present <= 1'b1;
        wait_st(sleep_seq_pkg::ST_SOFT_OFF, 1'b0);
        wake();
        wait_st(sleep_seq_pkg::ST_FULL_ON, 1'b0);
        // deep sleep entered from disk must come back to disk
        @(posedge clk_sys) ac_power_present <= 1'b0;
        wr(`SSQ_ADDR_CTRL, 32'h0000_0015);
        repeat (40) @(posedge clk_sys);
        rd(`SSQ_ADDR_STATE, state_word);
        `CHK({state_word[7:4], s5_plane_off_n}, {4'(sleep_seq_pkg::ST_DEEP_SLEEP), 1'b1})
        @(posedge clk_sys) ac_power_present <= 1'b1;
        wait_st(sleep_seq_pkg::ST_SUSPEND_DISK, 1'b0);
        wake();
        wait_st(sleep_seq_pkg::ST_FULL_ON, 1'b0);
        @(posedge clk_sys) ac_power_present <= 1'b0;
        wr(`SSQ_ADDR_CTRL, 32'h0000_0010);
        @(posedge clk_sys) pwr_button_override <= 1'b1;
        wait_st(sleep_seq_pkg::ST_DEEP_SLEEP, 1'b0);
        end_of_test();
    end
endmodule : test_sleep_seq
`default_nettype wire
